/* hdl/timer_pkg.sv */
// Package with register map, field layout and reset values of the up/down capture timer
//
// What this block does
// - A 16-bit unsigned up/down counter, ticked through a prescaler, loaded from reload_value.
// - reload_value is read/write, resets to zero, and supplies the counter start value.
// - clock_source_select picks the low-power oscillator, divided core clock, or core clock.
// - prescale_select divides the source by 1, 16, 256 or 32768.
// - count_direction set counts up, clear counts down; down after reset.
// - counter_run set runs the counter, clear halts it; halted after reset.
// - periodic_select set gives periodic mode, clear free-running; free-running after reset.
// - With capture enabled, each rising edge of the chosen source copies the count.
// - capture_source_select chooses one of the interrupt sources 0 to 17.
// - With capture disabled, capture_value never changes.
// - capture_value is read-only, holds the last capture, and resets to zero.
// - count_value is a read-only view of the live counter, all ones after reset.
// - Any write to irq_clear clears the terminal status only; the capture status is cleared by an ack register write with bit 1 set.

package timer_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] RELOAD_VALUE_ADDR  = 32'hffff_0380;
    localparam logic [31:0] COUNT_VALUE_ADDR   = 32'hffff_0384;
    localparam logic [31:0] TIMER_CONFIG_ADDR  = 32'hffff_0388;
    localparam logic [31:0] IRQ_CLEAR_ADDR     = 32'hffff_038c;
    localparam logic [31:0] CAPTURE_VALUE_ADDR = 32'hffff_0390;
    localparam logic [31:0] IRQ_STATUS_ADDR    = 32'hffff_0394;
    localparam logic [31:0] IRQ_ENABLE_ADDR    = 32'hffff_0398;
    localparam logic [31:0] IRQ_ACK_ADDR       = 32'hffff_039c;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [15:0] RELOAD_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_RESET    = 16'hffff;
    localparam logic [15:0] CAPTURE_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hffff;
    localparam logic [15:0] COUNT_MIN      = 16'h0000;
    localparam logic [15:0] COUNT_ONE      = 16'h0001;
    localparam logic [31:0] CONFIG_RESET   = 32'h0000_0000;
    localparam logic [31:0] CONFIG_WMASK   = 32'h0003_f7cf;

    // ------------------------------------------------------------------
    // Clock source and prescale encodings
    // ------------------------------------------------------------------
    localparam logic [1:0]  SRC_LP_OSC     = 2'h0;
    localparam logic [1:0]  SRC_CORE_DIV   = 2'h1;
    localparam logic [1:0]  SRC_CORE       = 2'h2;
    localparam logic [3:0]  PRESCALE_DIV1  = 4'h0;
    localparam logic [3:0]  PRESCALE_DIV16 = 4'h4;
    localparam logic [3:0]  PRESCALE_DIV256 = 4'h8;
    localparam logic [3:0]  PRESCALE_DIV32K = 4'hf;
    localparam logic [14:0] MASK_DIV1      = 15'h0000;
    localparam logic [14:0] MASK_DIV16     = 15'h000f;
    localparam logic [14:0] MASK_DIV256    = 15'h00ff;
    localparam logic [14:0] MASK_DIV32K    = 15'h7fff;

    // ------------------------------------------------------------------
    // Capture sources and interrupt status layout
    // ------------------------------------------------------------------
    localparam int          NUM_IRQ_SRC    = 18;
    localparam logic [4:0]  CAPSEL_MAX     = 5'h11;
    localparam int          STATUS_W       = 2;
    localparam int          STAT_TERMINAL  = 0;
    localparam int          STAT_CAPTURE   = 1;
    localparam logic [1:0]  STATUS_RESET   = 2'h0;

    typedef struct packed {
        logic [13:0] rsv_31_18;
        logic        capture_enable;
        logic [4:0]  capture_source_select;
        logic        rsv_11;
        logic [1:0]  clock_source_select;
        logic        count_direction;
        logic        counter_run;
        logic        periodic_select;
        logic [1:0]  rsv_5_4;
        logic [3:0]  prescale_select;
    } timer_config_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage

/* hdl/timer_prescaler.sv */
// Prescaler that turns source ticks into counter ticks
`timescale 1ns/100ps

module timer_prescaler (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       clear_i,
    input  wire logic       src_tick_i,
    input  wire logic [3:0] prescale_select_i,
    output logic            tick_o
);

    logic [14:0] div_cnt_ff;
    logic [14:0] div_mask;

    // Unlisted codes fall back to divide by one
    function automatic logic [14:0] prescale_mask(input logic [3:0] sel);
        case (sel)
            timer_pkg::PRESCALE_DIV16:  prescale_mask = timer_pkg::MASK_DIV16;
            timer_pkg::PRESCALE_DIV256: prescale_mask = timer_pkg::MASK_DIV256;
            timer_pkg::PRESCALE_DIV32K: prescale_mask = timer_pkg::MASK_DIV32K;
            default:                    prescale_mask = timer_pkg::MASK_DIV1;
        endcase
    endfunction

    assign div_mask = prescale_mask(prescale_select_i);
    assign tick_o   = src_tick_i && ((div_cnt_ff & div_mask) == div_mask);

    always_ff @(posedge clk_i) begin
        if (!rstn_i || clear_i) begin
            div_cnt_ff <= 15'h0000;
        end else if (tick_o) begin
            div_cnt_ff <= 15'h0000;
        end else if (src_tick_i) begin
            div_cnt_ff <= div_cnt_ff + 15'h0001;
        end
    end

endmodule

/* hdl/updown_timer.sv */
// Up/down timer with reload, capture on interrupt source and register access
`timescale 1ns/100ps

module updown_timer (
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    input  wire timer_pkg::reg_req_t      bus_req_i,
    output logic [31:0]                   rdata_o,
    input  wire logic                     lp_osc_i,
    input  wire logic [2:0]               core_clock_divider_i,
    input  wire logic [17:0]              irq_src_i,
    output logic                          irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    timer_pkg::timer_config_t cfg_ff;
    logic [15:0]              reload_value_ff;
    logic [15:0]              count_ff;
    logic [15:0]              nxt_count;
    logic [15:0]              capture_value_ff;
    logic [31:0]              rdata_ff;
    logic [2:0]               osc_sync_ff;
    logic                     osc_level_ff;
    logic                     osc_tick;
    logic [6:0]               core_div_ff;
    logic [6:0]               core_div_mask;
    logic                     core_div_tick;
    logic                     src_tick;
    logic                     count_tick;
    logic                     terminal;
    logic                     run_start;
    timer_pkg::timer_config_t wr_cfg;
    logic [17:0]              irq_prev_ff;
    logic [17:0]              irq_rise;
    logic                     capture_hit;
    logic [1:0]               status_ff;
    logic [1:0]               enable_ff;
    logic [1:0]               status_set;
    logic [1:0]               status_clr;
    logic                     wr_reload;
    logic                     wr_config;
    logic                     wr_irq_clear;
    logic                     wr_enable;
    logic                     wr_ack;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input timer_pkg::reg_req_t req,
                                      input logic [31:0]         target);
        addr_hit = req.wr && (req.addr == target);
    endfunction

    function automatic logic [6:0] divider_mask(input logic [2:0] cd);
        divider_mask = 7'((8'h01 << cd) - 8'h01);
    endfunction

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    assign wr_reload    = addr_hit(bus_req_i, timer_pkg::RELOAD_VALUE_ADDR);
    assign wr_config    = addr_hit(bus_req_i, timer_pkg::TIMER_CONFIG_ADDR);
    assign wr_irq_clear = addr_hit(bus_req_i, timer_pkg::IRQ_CLEAR_ADDR);
    assign wr_enable    = addr_hit(bus_req_i, timer_pkg::IRQ_ENABLE_ADDR);
    assign wr_ack       = addr_hit(bus_req_i, timer_pkg::IRQ_ACK_ADDR);

    // A start is a write that turns the run bit on while the timer is halted
    assign wr_cfg    = timer_pkg::timer_config_t'(bus_req_i.wdata);
    assign run_start = wr_config && !cfg_ff.counter_run && wr_cfg.counter_run;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            reload_value_ff <= timer_pkg::RELOAD_RESET;
        end else if (wr_reload) begin
            reload_value_ff <= bus_req_i.wdata[15:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cfg_ff <= timer_pkg::timer_config_t'(timer_pkg::CONFIG_RESET);
        end else if (wr_config) begin
            // Reserved positions are masked so they always hold zero
            cfg_ff <= timer_pkg::timer_config_t'(bus_req_i.wdata & timer_pkg::CONFIG_WMASK);
        end
    end

    // ------------------------------------------------------------------
    // Low-power oscillator synchroniser
    // ------------------------------------------------------------------
    // The oscillator pin is asynchronous to clk_i; its level only moves
    // once the second and third stages agree, so a glitch is not counted.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            osc_sync_ff <= 3'h0;
        end else begin
            osc_sync_ff <= {osc_sync_ff[1:0], lp_osc_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            osc_level_ff <= 1'b0;
        end else if (osc_sync_ff[1] == osc_sync_ff[2]) begin
            osc_level_ff <= osc_sync_ff[2];
        end
    end

    assign osc_tick = (osc_sync_ff[1] == osc_sync_ff[2]) && osc_sync_ff[2] && !osc_level_ff;

    // ------------------------------------------------------------------
    // Core clock divider
    // ------------------------------------------------------------------
    assign core_div_mask = divider_mask(core_clock_divider_i);
    assign core_div_tick = (core_div_ff & core_div_mask) == core_div_mask;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            core_div_ff <= 7'h00;
        end else if (core_div_tick) begin
            core_div_ff <= 7'h00;
        end else begin
            core_div_ff <= core_div_ff + 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // Source select and prescaler
    // ------------------------------------------------------------------
    // The reserved source code gives no ticks, so the counter stands still
    always_comb begin
        case (cfg_ff.clock_source_select)
            timer_pkg::SRC_LP_OSC:   src_tick = osc_tick;
            timer_pkg::SRC_CORE_DIV: src_tick = core_div_tick;
            timer_pkg::SRC_CORE:     src_tick = 1'b1;
            default:                 src_tick = 1'b0;
        endcase
    end

    timer_prescaler u_prescaler (
        .clk_i             (clk_i),
        .rstn_i            (rstn_i),
        .clear_i           (!cfg_ff.counter_run),
        .src_tick_i        (src_tick),
        .prescale_select_i (cfg_ff.prescale_select),
        .tick_o            (count_tick)
    );

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    assign terminal = cfg_ff.counter_run && count_tick
                      && (cfg_ff.count_direction ? (count_ff == timer_pkg::COUNT_MAX)
                                                 : (count_ff == timer_pkg::COUNT_MIN));

    always_comb begin
        nxt_count = count_ff;
        if (run_start) begin
            nxt_count = reload_value_ff;
        end else if (terminal && cfg_ff.periodic_select) begin
            nxt_count = reload_value_ff;
        end else if (cfg_ff.counter_run && count_tick) begin
            // Free-running wrap falls out of the 16-bit arithmetic
            if (cfg_ff.count_direction) begin
                nxt_count = count_ff + timer_pkg::COUNT_ONE;
            end else begin
                nxt_count = count_ff - timer_pkg::COUNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            count_ff <= timer_pkg::COUNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_prev_ff <= 18'h0_0000;
        end else begin
            irq_prev_ff <= irq_src_i;
        end
    end

    generate
        for (genvar i = 0; i < timer_pkg::NUM_IRQ_SRC; i++) begin : g_rise
            assign irq_rise[i] = irq_src_i[i] && !irq_prev_ff[i];
        end
    endgenerate

    // Out-of-range selects never trigger
    assign capture_hit = cfg_ff.capture_enable
                         && (cfg_ff.capture_source_select <= timer_pkg::CAPSEL_MAX)
                         && irq_rise[cfg_ff.capture_source_select];

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            capture_value_ff <= timer_pkg::CAPTURE_RESET;
        end else if (capture_hit) begin
            // The count before this edge's update is taken; counting is untouched
            capture_value_ff <= count_ff;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    assign status_set[timer_pkg::STAT_TERMINAL] = terminal;
    assign status_set[timer_pkg::STAT_CAPTURE]  = capture_hit;
    assign status_clr[timer_pkg::STAT_TERMINAL] = wr_irq_clear
                                                  || (wr_ack && bus_req_i.wdata[0]);
    assign status_clr[timer_pkg::STAT_CAPTURE]  = wr_ack && bus_req_i.wdata[1];

    // A new event in the clearing cycle wins so no event is lost
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            status_ff <= timer_pkg::STATUS_RESET;
        end else begin
            status_ff <= status_set | (status_ff & ~status_clr);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            enable_ff <= timer_pkg::STATUS_RESET;
        end else if (wr_enable) begin
            enable_ff <= bus_req_i.wdata[1:0];
        end
    end

    assign irq_o = |(status_ff & enable_ff);

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    // Write-only and unmapped addresses read as zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (bus_req_i.rd) begin
            case (bus_req_i.addr)
                timer_pkg::RELOAD_VALUE_ADDR:  rdata_ff <= {16'h0000, reload_value_ff};
                timer_pkg::COUNT_VALUE_ADDR:   rdata_ff <= {16'h0000, count_ff};
                timer_pkg::TIMER_CONFIG_ADDR:  rdata_ff <= 32'(cfg_ff);
                timer_pkg::CAPTURE_VALUE_ADDR: rdata_ff <= {16'h0000, capture_value_ff};
                timer_pkg::IRQ_STATUS_ADDR:    rdata_ff <= {30'h0000_0000, status_ff};
                timer_pkg::IRQ_ENABLE_ADDR:    rdata_ff <= {30'h0000_0000, enable_ff};
                default:                       rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_ff;

endmodule

/* tb/irq_src_model.sv */
// Model of the interrupt request lines and the low-power oscillator
`timescale 1ns/100ps

module irq_src_model (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        fire_i,
    input  wire logic [4:0]  line_i,
    output logic      [17:0] irq_src_o,
    output logic             lp_osc_o
);
    logic [3:0] hold_ff;
    logic [3:0] osc_ff;

    // A request line rises one cycle after fire_i and stays up four cycles
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            hold_ff   <= 4'h0;
            irq_src_o <= 18'h0_0000;
        end else if (fire_i) begin
            hold_ff   <= 4'h4;
            irq_src_o <= 18'h0_0001 << line_i;
        end else if (hold_ff != 4'h0) begin
            hold_ff <= hold_ff - 4'h1;
            if (hold_ff == 4'h1) begin
                irq_src_o <= 18'h0_0000;
            end
        end
    end

    // Oscillator sped up far beyond its real rate to keep runs short
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            osc_ff   <= 4'h0;
            lp_osc_o <= 1'b0;
        end else begin
            osc_ff <= osc_ff + 4'h1;
            if (osc_ff == 4'hf) begin
                lp_osc_o <= !lp_osc_o;
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the up/down capture timer
`timescale 1ns/100ps

module tb_top;
    logic                clk_i;
    logic                rstn_i;
    timer_pkg::reg_req_t req;
    logic [31:0]         rdata_o;
    logic [17:0]         irq_src;
    logic                lp_osc;
    logic                irq_o;
    logic                fire;
    logic [4:0]          line;
    logic [2:0]          cd;
    int                  bad_count;
    int                  check_count;

    // ------------------------------------------------------------------
    // Count cases: load, config, two reads, whether terminal was hit
    // ------------------------------------------------------------------
    localparam logic [15:0] LD_T [6] = '{16'h0003, 16'hfffe, 16'h0001,
                                         16'hfffd, 16'h0100, 16'h0100};
    localparam logic [31:0] CF_T [6] = '{32'h0000_04c0, 32'h0000_0580, 32'h0000_0480,
                                         32'h0000_05c0, 32'h0000_0680, 32'h0000_0488};
    localparam logic [15:0] E1_T [6] = '{16'h0002, 16'hffff, 16'h0000,
                                         16'hfffe, 16'h0100, 16'h0100};
    localparam logic [15:0] E2_T [6] = '{16'h0000, 16'h0001, 16'hfffe,
                                         16'hfffd, 16'h0100, 16'h0100};
    localparam logic [5:0]  TC_T     = 6'h0f;
    // Capture cases; the last two must leave the earlier capture alone
    localparam logic [15:0] CL_T [4] = '{16'h0100, 16'h0110, 16'h0200, 16'h0200};
    localparam logic [31:0] CC_T [4] = '{32'h0002_0480, 32'h0003_1480,
                                         32'h0001_1480, 32'h0002_5480};
    localparam logic [4:0]  LN_T [4] = '{5'h00, 5'h11, 5'h11, 5'h06};
    localparam logic [15:0] CE_T [4] = '{16'h00fe, 16'h010e, 16'h010e, 16'h010e};
    localparam logic [3:0]  HIT_T    = 4'h3;

    updown_timer dut_u (
        .clk_i                (clk_i),
        .rstn_i               (rstn_i),
        .bus_req_i            (req),
        .rdata_o              (rdata_o),
        .lp_osc_i             (lp_osc),
        .core_clock_divider_i (cd),
        .irq_src_i            (irq_src),
        .irq_o                (irq_o)
    );

    irq_src_model src_u (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .fire_i    (fire),
        .line_i    (line),
        .irq_src_o (irq_src),
        .lp_osc_o  (lp_osc)
    );

    always #5 clk_i = !clk_i;

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // Settle by one step so the edge's register updates have landed
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk_i);
        req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        bad_count++;
        end_sim();
    end

    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        req = '0;
        fire = 1'b0;
        line = 5'h00;
        cd = 3'h0;
        bad_count = 0;
        check_count = 0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(timer_pkg::RELOAD_VALUE_ADDR, 32'h0000_0000);
        rd(timer_pkg::COUNT_VALUE_ADDR, 32'h0000_ffff);
        rd(timer_pkg::TIMER_CONFIG_ADDR, 32'h0000_0000);
        rd(timer_pkg::CAPTURE_VALUE_ADDR, 32'h0000_0000);
        wr(timer_pkg::COUNT_VALUE_ADDR, 32'h0000_1234);
        rd(timer_pkg::COUNT_VALUE_ADDR, 32'h0000_ffff);
        wr(timer_pkg::CAPTURE_VALUE_ADDR, 32'h0000_0055);
        rd(timer_pkg::CAPTURE_VALUE_ADDR, 32'h0000_0000);
        wr(timer_pkg::TIMER_CONFIG_ADDR, 32'hfffc_0830);
        rd(timer_pkg::TIMER_CONFIG_ADDR, 32'h0000_0000);
        wr(timer_pkg::RELOAD_VALUE_ADDR, 32'hffff_abcd);
        rd(timer_pkg::RELOAD_VALUE_ADDR, 32'h0000_abcd);
        rd(32'hffff_03a0, 32'h0000_0000);
        rd(timer_pkg::IRQ_CLEAR_ADDR, 32'h0000_0000);
        wr(timer_pkg::IRQ_ENABLE_ADDR, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            wr(timer_pkg::RELOAD_VALUE_ADDR, {16'h0000, LD_T[i]});
            wr(timer_pkg::TIMER_CONFIG_ADDR, CF_T[i]);
            rd(timer_pkg::COUNT_VALUE_ADDR, {16'h0000, E1_T[i]});
            rd(timer_pkg::COUNT_VALUE_ADDR, {16'h0000, E2_T[i]});
            wr(timer_pkg::TIMER_CONFIG_ADDR, 32'h0000_0000);
            chk({31'h0, irq_o}, {31'h0, TC_T[i]});
            wr(timer_pkg::IRQ_CLEAR_ADDR, 32'h0000_00a5);
            chk({31'h0, irq_o}, 32'h0000_0000);
        end
        // Divided core clock, divider 8; with cd at zero the divider sits at
        // zero, so raising cd fixes the tick phase: ticks fall 8 edges later
        @(posedge clk_i);
        cd <= 3'h3;
        wr(timer_pkg::TIMER_CONFIG_ADDR, 32'h0000_0280);
        rd(timer_pkg::COUNT_VALUE_ADDR, 32'h0000_0100);
        repeat (8) @(posedge clk_i);
        rd(timer_pkg::COUNT_VALUE_ADDR, 32'h0000_00ff);
        wr(timer_pkg::TIMER_CONFIG_ADDR, 32'h0000_0000);
        // Oscillator source: a pin rise becomes a tick four edges later,
        // one tick every 32 cycles of the sped-up model
        @(posedge lp_osc);
        wr(timer_pkg::TIMER_CONFIG_ADDR, 32'h0000_0080);
        repeat (40) @(posedge clk_i);
        rd(timer_pkg::COUNT_VALUE_ADDR, 32'h0000_00fe);
        wr(timer_pkg::TIMER_CONFIG_ADDR, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(timer_pkg::RELOAD_VALUE_ADDR, {16'h0000, CL_T[i]});
            wr(timer_pkg::TIMER_CONFIG_ADDR, CC_T[i]);
            @(posedge clk_i);
            fire <= 1'b1;
            line <= LN_T[i];
            @(posedge clk_i);
            fire <= 1'b0;
            repeat (6) @(posedge clk_i);
            wr(timer_pkg::TIMER_CONFIG_ADDR, 32'h0000_0000);
            rd(timer_pkg::CAPTURE_VALUE_ADDR, {16'h0000, CE_T[i]});
            rd(timer_pkg::IRQ_STATUS_ADDR, {30'h0, HIT_T[i], 1'b0});
            chk({31'h0, irq_o}, 32'h0000_0000);
            wr(timer_pkg::IRQ_ENABLE_ADDR, 32'h0000_0003);
            chk({31'h0, irq_o}, {31'h0, HIT_T[i]});
            wr(timer_pkg::IRQ_ACK_ADDR, 32'h0000_0003);
            wr(timer_pkg::IRQ_ENABLE_ADDR, 32'h0000_0001);
            chk({31'h0, irq_o}, 32'h0000_0000);
        end
        end_sim();
    end
endmodule

/* tb/timer_sva.sv */
// Checker for the register port and interrupt output of the up/down timer
`timescale 1ns/100ps

module timer_sva (
    input wire logic                clk_i,
    input wire logic                rstn_i,
    input wire timer_pkg::reg_req_t bus_req_i,
    input wire logic [31:0]         rdata_o,
    input wire logic                lp_osc_i,
    input wire logic [2:0]          core_clock_divider_i,
    input wire logic [17:0]         irq_src_i,
    input wire logic                irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------------
    // Shadow of the interrupt enable register
    // ------------------------------------------------------------------
    logic [1:0] en_ff;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            en_ff <= 2'h0;
        end else if (bus_req_i.wr && bus_req_i.addr == timer_pkg::IRQ_ENABLE_ADDR) begin
            en_ff <= bus_req_i.wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Bus steps
    // ------------------------------------------------------------------
    sequence s_rd(logic [31:0] a);
        bus_req_i.rd && bus_req_i.addr == a;
    endsequence

    // A write, one quiet cycle, then a read of the same place
    sequence s_wr_rd(logic [31:0] a);
        bus_req_i.wr && bus_req_i.addr == a ##1 !bus_req_i.wr ##1 s_rd(a);
    endsequence

    chk_rdata_idle: assert property (!bus_req_i.rd |=> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside a read");
    chk_count_upper: assert property (
        s_rd(timer_pkg::COUNT_VALUE_ADDR) |=> rdata_o[31:16] == 16'h0000)
        else $error("count read has upper bits set");
    chk_capture_upper: assert property (
        s_rd(timer_pkg::CAPTURE_VALUE_ADDR) |=> rdata_o[31:16] == 16'h0000)
        else $error("capture read has upper bits set");
    chk_clear_wo: assert property (
        s_rd(timer_pkg::IRQ_CLEAR_ADDR) |=> rdata_o == 32'h0000_0000)
        else $error("clear register read not zero");
    chk_unmapped_zero: assert property (
        s_rd(32'hffff_03a0) |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_reload_back: assert property (
        s_wr_rd(timer_pkg::RELOAD_VALUE_ADDR)
        |=> rdata_o == {16'h0000, $past(bus_req_i.wdata[15:0], 3)})
        else $error("reload readback wrong");
    chk_config_back: assert property (
        s_wr_rd(timer_pkg::TIMER_CONFIG_ADDR)
        |=> rdata_o == ($past(bus_req_i.wdata, 3) & timer_pkg::CONFIG_WMASK))
        else $error("config readback wrong");
    chk_irq_masked: assert property (en_ff == 2'h0 |-> !irq_o)
        else $error("interrupt high with all sources masked");
endmodule

bind updown_timer timer_sva chk_u (
    .clk_i                (clk_i),
    .rstn_i               (rstn_i),
    .bus_req_i            (bus_req_i),
    .rdata_o              (rdata_o),
    .lp_osc_i             (lp_osc_i),
    .core_clock_divider_i (core_clock_divider_i),
    .irq_src_i            (irq_src_i),
    .irq_o                (irq_o)
);
